// *** rtl/rpg_map.vh ***
// register indices, field positions and reset values for rx power gating
`ifndef RPG_MAP_VH
`define RPG_MAP_VH

// register indices; byte address is four times the index
`define RPG_IDX_PIN_A_FDDC 10'h2C6
`define RPG_IDX_PIN_A_ALC 10'h2C7
`define RPG_IDX_PIN_A_LANE 10'h2C8
`define RPG_IDX_PIN_B_FDDC 10'h2C9
`define RPG_IDX_PIN_B_ALC 10'h2CA
`define RPG_IDX_PIN_B_LANE 10'h2CB
`define RPG_IDX_GPIO_A_FDDC 10'h2CE
`define RPG_IDX_GPIO_A_ALC 10'h2CF
`define RPG_IDX_GPIO_A_LANE 10'h2D0
`define RPG_IDX_GPIO_B_FDDC 10'h2D1
`define RPG_IDX_GPIO_B_ALC 10'h2D2
`define RPG_IDX_GPIO_B_LANE 10'h2D3
`define RPG_IDX_CTRL 10'h2FA
`define RPG_IDX_STATUS 10'h2FE

// slot numbering inside the mask store
`define RPG_SLOTS 12
`define RPG_SLOT_W 4
`define RPG_SLOTS_PER_SRC 3
`define RPG_SLOT_FDDC 0
`define RPG_SLOT_ALC 1
`define RPG_SLOT_LANE 2
`define RPG_SLOT_GPIO_BASE 10'h006

// fields of the adc / link / coarse ddc register
`define RPG_ADC_HI 7
`define RPG_ADC_LO 6
`define RPG_LINK_HI 5
`define RPG_LINK_LO 4
`define RPG_CDDC_HI 3
`define RPG_CDDC_LO 0

// control register bits
`define RPG_CTRL_PIN_A_USE_TX 0
`define RPG_CTRL_PIN_B_USE_TX 1
`define RPG_CTRL_POL_LO 2
`define RPG_CTRL_POL_HI 5
`define RPG_CTRL_W 6

// reset values
`define RPG_GATE_RST 8'h00
`define RPG_CTRL_RST 6'h00

// axi responses
`define RPG_RESP_OKAY 2'b00
`define RPG_RESP_SLVERR 2'b10

`endif

// *** rtl/rpg_mask_store.v ***
// storage for the twelve per-source gating mask bytes
`timescale 1ns/1ps
`include "rpg_map.vh"

module rpg_mask_store (
  input wire aclk,
  input wire aresetn,
  input wire aclken,
  input wire wr_en,
  input wire [3:0] wr_slot,
  input wire [7:0] wr_data,
  input wire rd_en,
  input wire [3:0] rd_slot,
  output reg [7:0] rd_data,
  output wire [95:0] all_masks
);

  genvar g;
  generate
    for (g = 0; g < `RPG_SLOTS; g = g + 1) begin : g_slot
      reg [7:0] mask;
      always @(posedge aclk) begin
        if (!aresetn) begin
          mask <= `RPG_GATE_RST;
        end else if (aclken && wr_en && wr_slot == g) begin
          mask <= wr_data;
        end
      end
      assign all_masks[g*8 +: 8] = mask;
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= `RPG_GATE_RST;
    end else if (aclken && rd_en) begin
      rd_data <= all_masks[rd_slot*8 +: 8];
    end
  end

endmodule // rpg_mask_store

// *** rtl/rpg_source_decode.v ***
// per-source decode of masks into gate requests
`timescale 1ns/1ps
`include "rpg_map.vh"

module rpg_source_decode (
  input wire level,
  input wire polarity,
  input wire [7:0] fine_ddc_mask,
  input wire [7:0] adc_link_cddc,
  input wire [7:0] lane_mask,
  output wire inactive,
  output wire [7:0] fine_gate,
  output wire [3:0] coarse_gate,
  output wire [3:0] adc_gate,
  output wire [1:0] link_gate,
  output wire [7:0] lane_gate
);

  wire [1:0] adc_sel;
  wire [3:0] adc_vec;

  assign inactive = ~(level ^ polarity);
  assign adc_sel = adc_link_cddc[`RPG_ADC_HI:`RPG_ADC_LO];
  assign adc_vec = {adc_sel[1], adc_sel[0], adc_sel[1], adc_sel[0]};

  assign fine_gate = fine_ddc_mask & {8{inactive}};
  assign coarse_gate = adc_link_cddc[`RPG_CDDC_HI:`RPG_CDDC_LO] &
    {4{inactive}};
  assign adc_gate = adc_vec & {4{inactive}};
  assign link_gate = adc_link_cddc[`RPG_LINK_HI:`RPG_LINK_LO] &
    {2{inactive}};
  assign lane_gate = lane_mask & {8{inactive}};

endmodule // rpg_source_decode

// *** rtl/rpg_top.v ***
// rx enable power gating: axi4-lite registers and gate outputs
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rpg_map.vh"

module rpg_top (
  input wire aclk,
  input wire aresetn,
  input wire aclken,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_pin_a,
  input wire rx_pin_b,
  input wire gpio_rx_a,
  input wire gpio_rx_b,
  input wire tx_pin_a,
  input wire tx_pin_b,
  output reg [7:0] fine_ddc_gate,
  output reg [3:0] coarse_ddc_gate,
  output reg [3:0] adc_gate,
  output reg [1:0] link_gate,
  output reg [7:0] lane_gate
);

  // write channel holding registers
  reg aw_held;
  reg [9:0] aw_idx;
  reg w_held;
  reg [7:0] w_byte;
  reg w_lane0;
  // read pipeline
  reg rd_pend;
  reg rd_from_store;
  reg rd_bad;
  reg [7:0] rd_local;
  // control: use-tx bits and polarities
  reg [`RPG_CTRL_W-1:0] ctrl;

  wire aw_take;
  wire w_take;
  wire ar_take;
  wire wr_go;
  wire [9:0] ar_idx;
  reg wr_store;
  reg wr_ctrl;
  reg [3:0] wr_slot;
  reg rd_store;
  reg rd_ctrl;
  reg rd_status;
  reg [3:0] rd_slot;
  // only the low four bits of a slot offset are kept
  reg [9:0] wr_off;
  reg [9:0] rd_off;
  wire store_we;
  wire [3:0] src_pol;

  wire [95:0] all_masks;
  wire [7:0] store_q;
  wire [3:0] src_level;
  wire [3:0] src_inactive;
  wire [31:0] fine_vec;
  wire [15:0] coarse_vec;
  wire [15:0] adc_vec;
  wire [7:0] link_vec;
  wire [31:0] lane_vec;
  reg [7:0] next_fine;
  reg [3:0] next_coarse;
  reg [3:0] next_adc;
  reg [1:0] next_link;
  reg [7:0] next_lane;
  integer k;

  // readies drop while the clock enable is low so nothing is lost
  assign s_axi_awready = aclken && !aw_held && !s_axi_bvalid;
  assign s_axi_wready = aclken && !w_held && !s_axi_bvalid;
  assign s_axi_arready = aclken && !rd_pend && !s_axi_rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_go = aclken && aw_held && w_held && !s_axi_bvalid;
  assign ar_idx = s_axi_araddr[11:2];

  // write decode; the gap between the pin and gpio groups is unmapped
  always @* begin
    wr_store = 1'b0;
    wr_ctrl = 1'b0;
    wr_off = 10'h000;
    wr_slot = 4'h0;
    if (aw_idx >= `RPG_IDX_PIN_A_FDDC && aw_idx <= `RPG_IDX_PIN_B_LANE) begin
      wr_store = 1'b1;
      wr_off = aw_idx - `RPG_IDX_PIN_A_FDDC;
      wr_slot = wr_off[3:0];
    end else if (aw_idx >= `RPG_IDX_GPIO_A_FDDC &&
                 aw_idx <= `RPG_IDX_GPIO_B_LANE) begin
      // gpio slots follow the six pin slots
      wr_store = 1'b1;
      wr_off = aw_idx - `RPG_IDX_GPIO_A_FDDC + `RPG_SLOT_GPIO_BASE;
      wr_slot = wr_off[3:0];
    end else if (aw_idx == `RPG_IDX_CTRL) begin
      wr_ctrl = 1'b1;
    end
  end

  // read decode, same map plus the status word
  always @* begin
    rd_store = 1'b0;
    rd_ctrl = 1'b0;
    rd_status = 1'b0;
    rd_off = 10'h000;
    rd_slot = 4'h0;
    if (ar_idx >= `RPG_IDX_PIN_A_FDDC && ar_idx <= `RPG_IDX_PIN_B_LANE) begin
      rd_store = 1'b1;
      rd_off = ar_idx - `RPG_IDX_PIN_A_FDDC;
      rd_slot = rd_off[3:0];
    end else if (ar_idx >= `RPG_IDX_GPIO_A_FDDC &&
                 ar_idx <= `RPG_IDX_GPIO_B_LANE) begin
      rd_store = 1'b1;
      rd_off = ar_idx - `RPG_IDX_GPIO_A_FDDC + `RPG_SLOT_GPIO_BASE;
      rd_slot = rd_off[3:0];
    end else if (ar_idx == `RPG_IDX_CTRL) begin
      rd_ctrl = 1'b1;
    end else if (ar_idx == `RPG_IDX_STATUS) begin
      rd_status = 1'b1;
    end
  end

  // address and data may arrive in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx <= 10'h000;
      w_held <= 1'b0;
      w_byte <= `RPG_GATE_RST;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RPG_RESP_OKAY;
    end else if (aclken) begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[11:2];
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // unmapped or read-only words: slverr and no effect
        s_axi_bresp <= (wr_store || wr_ctrl) ? `RPG_RESP_OKAY :
          `RPG_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register; only byte lane 0 carries data
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `RPG_CTRL_RST;
    end else if (wr_go && wr_ctrl && w_lane0) begin
      ctrl <= w_byte[`RPG_CTRL_W-1:0];
    end
  end

  // read: local values caught at the address edge, store is registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend <= 1'b0;
      rd_from_store <= 1'b0;
      rd_bad <= 1'b0;
      rd_local <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RPG_RESP_OKAY;
    end else if (aclken) begin
      if (ar_take) begin
        rd_pend <= 1'b1;
        rd_from_store <= rd_store;
        rd_bad <= !(rd_store || rd_ctrl || rd_status);
        // status is the live source state at the address edge
        rd_local <= rd_ctrl ? {2'b00, ctrl} :
          rd_status ? {4'h0, src_inactive} : 8'h00;
      end
      if (rd_pend) begin
        rd_pend <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_from_store ? store_q : rd_local};
        s_axi_rresp <= rd_bad ? `RPG_RESP_SLVERR : `RPG_RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // strobe lane 0 low: answered okay but nothing stored
  assign store_we = wr_go && wr_store && w_lane0;

  rpg_mask_store u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclken(aclken),
    .wr_en(store_we),
    .wr_slot(wr_slot),
    .wr_data(w_byte),
    .rd_en(ar_take),
    .rd_slot(rd_slot),
    .rd_data(store_q),
    .all_masks(all_masks)
  );

  assign src_level[0] = ctrl[`RPG_CTRL_PIN_A_USE_TX] ? tx_pin_a : rx_pin_a;
  assign src_level[1] = ctrl[`RPG_CTRL_PIN_B_USE_TX] ? tx_pin_b : rx_pin_b;
  assign src_level[2] = gpio_rx_a;
  assign src_level[3] = gpio_rx_b;

  assign src_pol = ctrl[`RPG_CTRL_POL_HI:`RPG_CTRL_POL_LO];

  genvar s;
  generate
    for (s = 0; s < 4; s = s + 1) begin : g_src
      rpg_source_decode u_dec (
        .level(src_level[s]),
        .polarity(src_pol[s]),
        .fine_ddc_mask(all_masks[(s*3 + `RPG_SLOT_FDDC)*8 +: 8]),
        .adc_link_cddc(all_masks[(s*3 + `RPG_SLOT_ALC)*8 +: 8]),
        .lane_mask(all_masks[(s*3 + `RPG_SLOT_LANE)*8 +: 8]),
        .inactive(src_inactive[s]),
        .fine_gate(fine_vec[s*8 +: 8]),
        .coarse_gate(coarse_vec[s*4 +: 4]),
        .adc_gate(adc_vec[s*4 +: 4]),
        .link_gate(link_vec[s*2 +: 2]),
        .lane_gate(lane_vec[s*8 +: 8])
      );
    end
  endgenerate

  always @* begin
    next_fine = 8'h00;
    next_coarse = 4'h0;
    next_adc = 4'h0;
    next_link = 2'b00;
    next_lane = 8'h00;
    for (k = 0; k < 4; k = k + 1) begin
      next_fine = next_fine | fine_vec[k*8 +: 8];
      next_coarse = next_coarse | coarse_vec[k*4 +: 4];
      next_adc = next_adc | adc_vec[k*4 +: 4];
      next_link = next_link | link_vec[k*2 +: 2];
      next_lane = next_lane | lane_vec[k*8 +: 8];
    end
  end

  // registered gates keep glitches off the clock gaters
  always @(posedge aclk) begin
    if (!aresetn) begin
      fine_ddc_gate <= 8'h00;
      coarse_ddc_gate <= 4'h0;
      adc_gate <= 4'h0;
      link_gate <= 2'b00;
      lane_gate <= 8'h00;
    end else if (aclken) begin
      fine_ddc_gate <= next_fine;
      coarse_ddc_gate <= next_coarse;
      adc_gate <= next_adc;
      link_gate <= next_link;
      lane_gate <= next_lane;
    end
  end

endmodule // rpg_top

// *** sim/rpg_properties.sv ***
// port checker for rx enable power gating
`timescale 1ns/1ps
module rpg_properties (
  input wire aclk,
  input wire aresetn,
  input wire aclken,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_pin_a,
  input wire rx_pin_b,
  input wire gpio_rx_a,
  input wire gpio_rx_b,
  input wire tx_pin_a,
  input wire tx_pin_b,
  input wire [7:0] fine_ddc_gate,
  input wire [3:0] coarse_ddc_gate,
  input wire [3:0] adc_gate,
  input wire [1:0] link_gate,
  input wire [7:0] lane_gate
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire [5:0] src = {tx_pin_b, tx_pin_a, gpio_rx_b, gpio_rx_a, rx_pin_b,
    rx_pin_a};
  wire [25:0] gates = {fine_ddc_gate, coarse_ddc_gate, adc_gate, link_gate,
    lane_gate};
  reg written;
  // masks can only be nonzero after an accepted write
  always @(posedge aclk) begin
    if (!aresetn)
      written <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      written <= 1'b1;
  end
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_no_gate_unwritten: assert property (
    !written |-> gates == 26'h000_0000)
    else $error("gate set with reset masks");
  a_gate_steady: assert property ($stable(src) && !s_axi_bvalid &&
    !$past(s_axi_bvalid) && $past(aclken) |=> $stable(gates))
    else $error("gate moved without cause");
  a_ce_freeze: assert property (!aclken |=> $stable(gates))
    else $error("gate moved while clock enable low");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_answer: assert property (s_ar_take |-> ##[1:3] s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  a_aw_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_rdata_byte: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
endmodule // rpg_properties

// *** sim/rpg_host.sv ***
// host model driving the enable lines
`timescale 1ns/1ps
module rpg_host (
  input wire aclk,
  input wire [5:0] want,
  output reg [5:0] lines
);
  initial lines = 6'h3f;
  always @(posedge aclk) lines <= want;
endmodule // rpg_host

// *** sim/tb_rx_enable_power_gating.sv ***
// testbench for rx enable power gating
`timescale 1ns/1ps
`include "rpg_map.vh"
module tb_rx_enable_power_gating;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [11:0] aw = 0, ar = 0;
  logic [31:0] wd = 0;
  logic ce = 1;
  logic [3:0] ws = 4'hf;
  logic [5:0] want = 6'h3f;
  wire awr, wrdy, bv, arr, rv;
  wire [1:0] brsp, rrsp;
  wire [31:0] rdt;
  wire [5:0] ln6;
  wire [7:0] fd, lnm;
  wire [3:0] cd, ad;
  wire [1:0] lk;
  int n_errors = 0, comparisons = 0;
  always #20 aclk = ~aclk;
  rpg_host host (.aclk(aclk), .want(want), .lines(ln6));
  rpg_top uut (.aclk(aclk), .aresetn(aresetn), .aclken(ce),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(brsp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rrsp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .rx_pin_a(ln6[0]),
    .rx_pin_b(ln6[1]), .gpio_rx_a(ln6[2]), .gpio_rx_b(ln6[3]),
    .tx_pin_a(ln6[4]), .tx_pin_b(ln6[5]), .fine_ddc_gate(fd),
    .coarse_ddc_gate(cd), .adc_gate(ad), .link_gate(lk), .lane_gate(lnm));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // both channels offered together, released when taken
  task automatic wx(input logic [9:0] i, input logic [7:0] d,
    input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    logic [1:0] r;
    n = 0;
    tb = 0;
    @(posedge aclk);
    aw <= {i, 2'b00};
    wd <= {24'h00_0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!tb && n < 50) begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wrdy;
      tb = bv && br;
      r = brsp;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) br <= 1'b0;
      n++;
    end
    chk({31'h0000_0000, tb}, 32'h0000_0001);
    chk({30'h0000_0000, r}, {30'h0000_0000, er});
  endtask
  task automatic rx(input logic [9:0] i, input logic [7:0] e,
    input logic [1:0] er);
    int n;
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    tr = 0;
    @(posedge aclk);
    ar <= {i, 2'b00};
    arv <= 1'b1;
    rr <= 1'b1;
    while (!tr && n < 50) begin
      @(negedge aclk);
      ta = arv && arr;
      tr = rv && rr;
      d = rdt;
      r = rrsp;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
      if (tr) rr <= 1'b0;
      n++;
    end
    chk({31'h0000_0000, tr}, 32'h0000_0001);
    chk(d, {24'h00_0000, e});
    chk({30'h0000_0000, r}, {30'h0000_0000, er});
  endtask
  // lines land one edge, gates the next
  task automatic gx(input logic [5:0] w, input logic [25:0] e);
    @(posedge aclk);
    want <= w;
    repeat (3) @(posedge aclk);
    #1;
    chk({6'h00, fd, cd, ad, lk, lnm}, {6'h00, e});
  endtask
  task automatic t_reset;
    logic [9:0] idx [12];
    idx = '{`RPG_IDX_PIN_A_FDDC, `RPG_IDX_PIN_A_ALC, `RPG_IDX_PIN_A_LANE,
      `RPG_IDX_PIN_B_FDDC, `RPG_IDX_PIN_B_ALC, `RPG_IDX_PIN_B_LANE,
      `RPG_IDX_GPIO_A_FDDC, `RPG_IDX_GPIO_A_ALC, `RPG_IDX_GPIO_A_LANE,
      `RPG_IDX_GPIO_B_FDDC, `RPG_IDX_GPIO_B_ALC, `RPG_IDX_GPIO_B_LANE};
    foreach (idx[k]) rx(idx[k], 8'h00, `RPG_RESP_OKAY);
    rx(`RPG_IDX_CTRL, 8'h00, `RPG_RESP_OKAY);
    gx(6'h30, 26'h000_0000);
    $display("test reset done");
  endtask
  task automatic t_fields;
    wx(`RPG_IDX_PIN_A_FDDC, 8'ha5, `RPG_RESP_OKAY);
    wx(`RPG_IDX_PIN_A_ALC, 8'h6c, `RPG_RESP_OKAY);
    wx(`RPG_IDX_PIN_A_LANE, 8'h3c, `RPG_RESP_OKAY);
    rx(`RPG_IDX_PIN_A_ALC, 8'h6c, `RPG_RESP_OKAY);
    gx(6'h3e, {8'ha5, 4'hc, 4'h5, 2'h2, 8'h3c});
    gx(6'h3f, 26'h000_0000);
    $display("test fields done");
  endtask
  task automatic t_adc;
    logic [3:0] e [4];
    e = '{4'h0, 4'h5, 4'ha, 4'hf};
    for (int c = 0; c < 4; c++) begin
      wx(`RPG_IDX_GPIO_B_ALC, {c[1:0], 6'h00}, `RPG_RESP_OKAY);
      gx(6'h37, {12'h000, e[c], 10'h000});
    end
    gx(6'h3f, 26'h000_0000);
    $display("test adc done");
  endtask
  task automatic t_or;
    wx(`RPG_IDX_PIN_B_FDDC, 8'h0f, `RPG_RESP_OKAY);
    wx(`RPG_IDX_GPIO_A_FDDC, 8'h3c, `RPG_RESP_OKAY);
    gx(6'h3d, {8'h0f, 18'h0_0000});
    gx(6'h3b, {8'h3c, 18'h0_0000});
    gx(6'h39, {8'h3f, 18'h0_0000});
    $display("test shared done");
  endtask
  task automatic t_pol;
    wx(`RPG_IDX_CTRL, 8'h12, `RPG_RESP_OKAY);
    gx(6'h3f, {8'h3c, 18'h0_0000});
    gx(6'h1f, {8'h3f, 18'h0_0000});
    rx(`RPG_IDX_STATUS, 8'h06, `RPG_RESP_OKAY);
    rx(`RPG_IDX_CTRL, 8'h12, `RPG_RESP_OKAY);
    gx(6'h39, 26'h000_0000);
    wx(`RPG_IDX_CTRL, 8'h00, `RPG_RESP_OKAY);
    gx(6'h3f, 26'h000_0000);
    $display("test polarity done");
  endtask
  task automatic t_ce;
    wx(`RPG_IDX_PIN_A_LANE, 8'h81, `RPG_RESP_OKAY);
    @(posedge aclk);
    ce <= 1'b0;
    gx(6'h3e, 26'h000_0000);
    chk({29'h0000_0000, awr, wrdy, arr}, 32'h0000_0000);
    @(posedge aclk);
    ce <= 1'b1;
    gx(6'h3e, {8'ha5, 4'hc, 4'h5, 2'h2, 8'h81});
    gx(6'h3f, 26'h000_0000);
    $display("test clock enable done");
  endtask
  task automatic t_again;
    wx(`RPG_IDX_GPIO_B_LANE, 8'hff, `RPG_RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rx(`RPG_IDX_GPIO_B_LANE, 8'h00, `RPG_RESP_OKAY);
    rx(`RPG_IDX_PIN_A_FDDC, 8'h00, `RPG_RESP_OKAY);
    gx(6'h30, 26'h000_0000);
    $display("test second reset done");
  endtask
  task automatic t_bad;
    @(posedge aclk);
    ws <= 4'h0;
    wx(`RPG_IDX_PIN_B_LANE, 8'hff, `RPG_RESP_OKAY);
    ws <= 4'hf;
    rx(`RPG_IDX_PIN_B_LANE, 8'h00, `RPG_RESP_OKAY);
    wx(10'h000, 8'hff, `RPG_RESP_SLVERR);
    rx(10'h000, 8'h00, `RPG_RESP_SLVERR);
    wx(`RPG_IDX_STATUS, 8'hff, `RPG_RESP_SLVERR);
    $display("test unmapped done");
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_fields();
    t_adc();
    t_or();
    t_pol();
    t_ce();
    t_bad();
    t_again();
    conclude();
  end
  // run needs under a thousand cycles
  initial begin
    #800000;
    n_errors++;
    conclude();
  end
endmodule // tb_rx_enable_power_gating
bind rpg_top rpg_properties chk_i (.aclk, .aresetn, .aclken, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .rx_pin_a, .rx_pin_b, .gpio_rx_a, .gpio_rx_b, .tx_pin_a,
  .tx_pin_b, .fine_ddc_gate, .coarse_ddc_gate, .adc_gate, .link_gate,
  .lane_gate);
